// ### pacc_pkg.sv
// Purpose: constants shared by the auxiliary coding control block
// Assumes: 16-bit registers on a plain strobe port, word indexed
// Notes: one constant for each offset, field, reset value and count
package pacc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_TEN_BASE_STATUS = 4'h0;
  localparam logic [3:0] OFS_FAST_CONTROL = 4'h1;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_CLEAR = 4'h3;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'h4;

  // ----------------------------------------------------------------------
  // 10BASE-T auxiliary error status fields
  // ----------------------------------------------------------------------
  localparam int ST_POLARITY = 8;
  localparam int ST_EOF_ERR = 9;
  localparam int ST_MANCH_ERR = 10;

  // ----------------------------------------------------------------------
  // 100BASE-X auxiliary control fields
  // ----------------------------------------------------------------------
  localparam int CT_OOB_EN = 1;
  localparam int CT_EXT_FIFO_EN = 2;
  localparam int CT_FEF_EN = 5;
  localparam int CT_BLW_DIS = 6;
  localparam int CT_BYP_ALIGN = 7;
  localparam int CT_BYP_MLT3 = 8;
  localparam int CT_BYP_SCRAM = 9;
  localparam int CT_BYP_4B5B = 10;
  localparam int CT_CIM_DIS = 12;
  localparam int CT_TX_DIS = 13;
  localparam logic [15:0] CT_WRITE_MASK = 16'h37E6;
  localparam logic [15:0] CT_RESET = 16'h1000;

  // ----------------------------------------------------------------------
  // interrupt status, clear and enable layout
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_POLARITY = 0;
  localparam int IRQ_EOF_ERR = 1;
  localparam int IRQ_MANCH_ERR = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // pin synchroniser and strap capture
  // ----------------------------------------------------------------------
  localparam int PIN_W = 3;
  localparam int PIN_RX_LINE = 0;
  localparam int PIN_STRAP = 1;
  localparam int PIN_CIM_SEL = 2;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

endpackage : pacc_pkg

// ### pacc_top.sv
// Purpose: auxiliary control and status of a 10/100 PHY coding path
// Assumes: one 40 MHz clock; cable level and straps arrive as pins
// Notes: control outputs steer the 100BASE-X path stages outside

module pacc_top
  import pacc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq,
  // pins from outside the clock domain
  input wire logic rx_line,
  input wire logic repeater_strap,
  input wire logic cim_mode_select,
  // 10BASE-T receive events from same-clock logic
  input wire logic ten_base_mode,
  input wire logic rx_frame_active,
  input wire logic eof_error_event,
  input wire logic manchester_error_event,
  // 100BASE-X receive path from same-clock logic
  input wire logic [3:0] rx_nibble,
  input wire logic rx_nibble_err,
  input wire logic [4:0] rx_code_aligned,
  input wire logic [4:0] rx_code_unaligned,
  input wire logic rx_valid_frame,
  // MII transmit side and encoder output
  input wire logic txen,
  input wire logic txer,
  input wire logic [3:0] txd,
  input wire logic [4:0] enc_code,
  input wire logic tx_serial,
  // MII receive side
  output logic [3:0] rxd,
  output logic rxer,
  output logic crs,
  output logic rx_line_corrected,
  // coding path steering
  output logic [4:0] scrambler_code,
  output logic delimiter_insert_en,
  output logic oob_signal_en,
  output logic ext_fifo_en,
  output logic far_end_fault_signal_en,
  output logic baseline_wander_en,
  output logic symbol_align_en,
  output logic mlt3_en,
  output logic scrambler_en,
  output logic carrier_integrity_monitor_en,
  // line transmit pin, two signals
  output logic line_transmit_output_o,
  output logic line_transmit_output_oe
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------

  // next value of a sticky flag; set wins over clear
  function automatic logic sticky_next(input logic cur, input logic set,
                                       input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction : sticky_next

  // next value of a control word under the writable mask
  function automatic logic [15:0] masked_write(input logic [15:0] cur,
                                               input logic [15:0] wd);
    masked_write = (wd & CT_WRITE_MASK) | (cur & ~CT_WRITE_MASK);
  endfunction : masked_write

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {cim_mode_select, repeater_strap, rx_line};

  // three stages; a level counts once the last two agree
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < PIN_W; i++)
      begin
        if (pin_s2_q[i] == pin_s3_q[i])
        begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic rd_status;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_FAST_CONTROL);
  assign wr_irq_clear = reg_wr && (reg_addr == OFS_IRQ_CLEAR);
  assign wr_irq_enable = reg_wr && (reg_addr == OFS_IRQ_ENABLE);
  assign rd_status = reg_rd && (reg_addr == OFS_TEN_BASE_STATUS);

  // ----------------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------------
  logic [1:0] strap_wait_q;
  logic strap_ready_q;
  logic strap_done_q;
  logic strap_load;

  assign strap_load = !strap_done_q && strap_ready_q;

  // waits for the synchroniser to fill, then loads once
  // filtered pins land one edge after the count ends, so load waits
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strap_wait_q <= 2'h0;
      strap_ready_q <= 1'b0;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      if (strap_load)
      begin
        strap_done_q <= 1'b1;
      end
      else if (strap_wait_q == STRAP_SETTLE_CYCLES)
      begin
        strap_ready_q <= 1'b1;
      end
      else
      begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // 100BASE-X auxiliary control register
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;

  // software write, then strap load of the monitor disable bit
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d = masked_write(ctrl_q, reg_wdata);
    end
    if (strap_load)
    begin
      // strap high: select pin decides; strap low: monitor stays off
      ctrl_d[CT_CIM_DIS] = pin_q[PIN_STRAP] ? pin_q[PIN_CIM_SEL]
                                            : 1'b1;
    end
  end

  // control word storage
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= CT_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------------
  // stage enables derived from the control word
  // ----------------------------------------------------------------------

  // each stage steered by its own bit, registered onto the outputs
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oob_signal_en <= 1'b0;
      ext_fifo_en <= 1'b0;
      far_end_fault_signal_en <= 1'b0;
      baseline_wander_en <= 1'b1;
      symbol_align_en <= 1'b1;
      mlt3_en <= 1'b1;
      scrambler_en <= 1'b1;
      delimiter_insert_en <= 1'b1;
      carrier_integrity_monitor_en <= 1'b0;
    end
    else
    begin
      oob_signal_en <= ctrl_q[CT_OOB_EN];
      ext_fifo_en <= ctrl_q[CT_EXT_FIFO_EN];
      far_end_fault_signal_en <= ctrl_q[CT_FEF_EN];
      baseline_wander_en <= !ctrl_q[CT_BLW_DIS];
      symbol_align_en <= !ctrl_q[CT_BYP_ALIGN];
      mlt3_en <= !ctrl_q[CT_BYP_MLT3];
      scrambler_en <= !ctrl_q[CT_BYP_SCRAM];
      delimiter_insert_en <= !ctrl_q[CT_BYP_4B5B];
      carrier_integrity_monitor_en <= !ctrl_q[CT_CIM_DIS];
    end
  end

  // ----------------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------------

  // raw MII codes reach the scrambler only while the MAC holds enable
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scrambler_code <= 5'h00;
    end
    else if (ctrl_q[CT_BYP_4B5B])
    begin
      scrambler_code <= txen ? {txer, txd} : 5'h00;
    end
    else
    begin
      scrambler_code <= enc_code;
    end
  end

  // line driver; disabled transmitter releases the pin
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      line_transmit_output_o <= 1'b0;
      line_transmit_output_oe <= 1'b0;
    end
    else
    begin
      line_transmit_output_o <= ctrl_q[CT_TX_DIS] ? 1'b0 : tx_serial;
      line_transmit_output_oe <= !ctrl_q[CT_TX_DIS];
    end
  end

  // ----------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------

  // MII receive selection: nibble, aligned code or unaligned code
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxd <= 4'h0;
      rxer <= 1'b0;
    end
    else if (ctrl_q[CT_BYP_4B5B] && ctrl_q[CT_BYP_ALIGN])
    begin
      {rxer, rxd} <= rx_code_unaligned;
    end
    else if (ctrl_q[CT_BYP_4B5B])
    begin
      {rxer, rxd} <= rx_code_aligned;
    end
    else
    begin
      rxd <= rx_nibble;
      rxer <= rx_nibble_err;
    end
  end

  // carrier sense follows valid frames in every coding mode
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      crs <= 1'b0;
    end
    else
    begin
      crs <= rx_valid_frame;
    end
  end

  // ----------------------------------------------------------------------
  // receive polarity detection and correction
  // ----------------------------------------------------------------------
  logic frame_active_q;
  logic frame_end;
  logic polarity_inv_q;
  logic polarity_change;

  assign frame_end = frame_active_q && !rx_frame_active && ten_base_mode;
  // an idle that ends low means the pair is swapped
  assign polarity_change = frame_end && (polarity_inv_q == pin_q[PIN_RX_LINE]);

  // frame edge tracking and polarity decision
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frame_active_q <= 1'b0;
      polarity_inv_q <= 1'b0;
    end
    else
    begin
      frame_active_q <= rx_frame_active;
      if (frame_end)
      begin
        polarity_inv_q <= !pin_q[PIN_RX_LINE];
      end
    end
  end

  // corrected line, no error reported for the inversion
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_line_corrected <= 1'b0;
    end
    else
    begin
      rx_line_corrected <= pin_q[PIN_RX_LINE] ^ polarity_inv_q;
    end
  end

  // ----------------------------------------------------------------------
  // 10BASE-T error flags
  // ----------------------------------------------------------------------
  logic eof_err_q;
  logic manch_err_q;
  logic eof_set;
  logic manch_set;

  assign eof_set = eof_error_event && ten_base_mode;
  assign manch_set = manchester_error_event && ten_base_mode;

  // flags hold until the status register is read
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      eof_err_q <= 1'b0;
      manch_err_q <= 1'b0;
    end
    else
    begin
      eof_err_q <= sticky_next(eof_err_q, eof_set, rd_status);
      manch_err_q <= sticky_next(manch_err_q, manch_set, rd_status);
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, enable and output
  // ----------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic [IRQ_W-1:0] irq_events;

  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_POLARITY] = polarity_change;
    irq_events[IRQ_EOF_ERR] = eof_set;
    irq_events[IRQ_MANCH_ERR] = manch_set;
  end

  // sticky event bits, cleared by writing ones
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_status_q <= IRQ_RESET;
    end
    else
    begin
      for (int i = 0; i < IRQ_W; i++)
      begin
        irq_status_q[i] <= sticky_next(irq_status_q[i], irq_events[i],
                                       wr_irq_clear && reg_wdata[i]);
      end
    end
  end

  // interrupt enable mask
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_enable_q <= IRQ_RESET;
    end
    else if (wr_irq_enable)
    begin
      irq_enable_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  // level interrupt while an enabled bit is set
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [15:0] rdata_d;

  // read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    rdata_d = 16'h0000;
    case (reg_addr)
      OFS_TEN_BASE_STATUS:
      begin
        rdata_d[ST_POLARITY] = polarity_inv_q;
        rdata_d[ST_EOF_ERR] = eof_err_q;
        rdata_d[ST_MANCH_ERR] = manch_err_q;
      end
      OFS_FAST_CONTROL:
      begin
        rdata_d = ctrl_q & CT_WRITE_MASK;
      end
      OFS_IRQ_STATUS:
      begin
        rdata_d[IRQ_W-1:0] = irq_status_q;
      end
      OFS_IRQ_ENABLE:
      begin
        rdata_d[IRQ_W-1:0] = irq_enable_q;
      end
      default:
      begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
    else
    begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : pacc_top

// ### pacc_monitor.sv
// Purpose: port checks for the auxiliary coding control block
// Assumes: one clock domain, reset active high
// Notes: bound to pacc_top below the module
module pacc_monitor
  import pacc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // receive events and paths, MII transmit pins
  input wire logic ten_base_mode,
  input wire logic eof_error_event,
  input wire logic manchester_error_event,
  input wire logic [4:0] rx_code_aligned,
  input wire logic [4:0] rx_code_unaligned,
  input wire logic rx_valid_frame,
  input wire logic txen,
  input wire logic txer,
  input wire logic [3:0] txd,
  // outputs watched
  input wire logic [3:0] rxd,
  input wire logic rxer,
  input wire logic crs,
  input wire logic [4:0] scrambler_code,
  input wire logic delimiter_insert_en,
  input wire logic oob_signal_en,
  input wire logic ext_fifo_en,
  input wire logic far_end_fault_signal_en,
  input wire logic baseline_wander_en,
  input wire logic symbol_align_en,
  input wire logic mlt3_en,
  input wire logic scrambler_en,
  input wire logic carrier_integrity_monitor_en,
  input wire logic line_transmit_output_o,
  input wire logic line_transmit_output_oe
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] wd1_q;
  logic [15:0] wd2_q;
  // write data delayed to meet the steering outputs
  always_ff @(posedge clock)
  begin
    wd1_q <= reg_wdata;
    wd2_q <= wd1_q;
  end
  // control write, then two edges to the outputs
  sequence ctl_wr;
    reg_wr && reg_addr == OFS_FAST_CONTROL ##2 1'b1;
  endsequence
  // 10BASE-T event, then a status read
  sequence eof_rd;
    ten_base_mode && eof_error_event
    ##[1:2] reg_rd && reg_addr == OFS_TEN_BASE_STATUS;
  endsequence
  sequence manch_rd;
    ten_base_mode && manchester_error_event
    ##[1:2] reg_rd && reg_addr == OFS_TEN_BASE_STATUS;
  endsequence
  // ----------
  // checks
  // ----------
  chk_oob_follow:
    assert property (ctl_wr |-> oob_signal_en == wd2_q[CT_OOB_EN])
    else $error("oob enable wrong");
  chk_fifo_follow:
    assert property (ctl_wr |-> ext_fifo_en == wd2_q[CT_EXT_FIFO_EN])
    else $error("fifo enable wrong");
  chk_fef_follow:
    assert property (ctl_wr |-> far_end_fault_signal_en == wd2_q[CT_FEF_EN])
    else $error("fault enable wrong");
  chk_wander_ctl:
    assert property (ctl_wr |-> baseline_wander_en == !wd2_q[CT_BLW_DIS])
    else $error("wander enable wrong");
  chk_align_ctl:
    assert property (ctl_wr |-> symbol_align_en == !wd2_q[CT_BYP_ALIGN])
    else $error("align enable wrong");
  chk_mlt3_ctl:
    assert property (ctl_wr |-> mlt3_en == !wd2_q[CT_BYP_MLT3])
    else $error("mlt3 enable wrong");
  chk_scram_ctl:
    assert property (ctl_wr |-> scrambler_en == !wd2_q[CT_BYP_SCRAM])
    else $error("scrambler enable wrong");
  chk_monitor_ctl:
    assert property (ctl_wr |->
      carrier_integrity_monitor_en == !wd2_q[CT_CIM_DIS])
    else $error("monitor enable wrong");
  chk_tx_disable:
    assert property (ctl_wr |->
      line_transmit_output_oe == !wd2_q[CT_TX_DIS])
    else $error("transmit enable wrong");
  chk_tx_hiz:
    assert property (!line_transmit_output_oe |-> !line_transmit_output_o)
    else $error("line driven while off");
  chk_unused_zero:
    assert property (reg_rd && reg_addr == OFS_FAST_CONTROL |=>
      (reg_rdata & ~CT_WRITE_MASK) == 16'h0000)
    else $error("unused control bits set");
  chk_rx_aligned:
    assert property (!delimiter_insert_en && symbol_align_en |->
      {rxer, rxd} == $past(rx_code_aligned))
    else $error("aligned code wrong");
  chk_rx_unaligned:
    assert property (!delimiter_insert_en && !symbol_align_en |->
      {rxer, rxd} == $past(rx_code_unaligned))
    else $error("unaligned code wrong");
  chk_tx_passthru:
    assert property (!delimiter_insert_en && $past(txen) |->
      scrambler_code == $past({txer, txd}))
    else $error("transmit code wrong");
  chk_carrier_follow:
    assert property (!$past(sys_rst) |-> crs == $past(rx_valid_frame))
    else $error("carrier sense wrong");
  chk_eof_flag:
    assert property (eof_rd |=> reg_rdata[ST_EOF_ERR])
    else $error("end of frame flag lost");
  chk_manch_flag:
    assert property (manch_rd |=> reg_rdata[ST_MANCH_ERR])
    else $error("code violation flag lost");
endmodule : pacc_monitor

bind pacc_top pacc_monitor u_mon (
  .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ten_base_mode, .eof_error_event, .manchester_error_event,
  .rx_code_aligned, .rx_code_unaligned, .rx_valid_frame,
  .txen, .txer, .txd, .rxd, .rxer, .crs, .scrambler_code,
  .delimiter_insert_en, .oob_signal_en, .ext_fifo_en,
  .far_end_fault_signal_en, .baseline_wander_en, .symbol_align_en,
  .mlt3_en, .scrambler_en, .carrier_integrity_monitor_en,
  .line_transmit_output_o, .line_transmit_output_oe
);

// ### pacc_mac_model.sv
// Purpose: MAC side of the MII transmit pins
// Assumes: request lands on the edge after the bench raises send
// Notes: idle data lines toggle so a stale code never looks valid
module pacc_mac_model
(
  // clock and request
  input wire logic clock,
  input wire logic send,
  input wire logic [4:0] code,
  // MII transmit pins
  output logic txen = 1'b0,
  output logic txer = 1'b0,
  output logic [3:0] txd = 4'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // enable held for the whole coded burst
  always @(posedge clock)
  begin
    txen <= send;
    if (send)
      {txer, txd} <= code;
    else
      {txer, txd} <= ~{txer, txd};
  end
endmodule : pacc_mac_model

// ### tb_pacc_top.sv
// Purpose: self-checking bench for the auxiliary coding control block
// Assumes: 40 MHz clock, reset held 12 cycles
// Notes: straps settle before the first register access
module tb_pacc_top
  import pacc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_line = 1'b1;
  logic repeater_strap = 1'b1;
  logic cim_mode_select = 1'b0;
  logic ten_base_mode = 1'b0;
  logic rx_frame_active = 1'b0;
  logic eof_error_event = 1'b0;
  logic manchester_error_event = 1'b0;
  logic [3:0] rx_nibble = 4'h6;
  logic rx_nibble_err = 1'b1;
  logic [4:0] rx_code_aligned = 5'h0B;
  logic [4:0] rx_code_unaligned = 5'h14;
  logic rx_valid_frame = 1'b0;
  logic [4:0] enc_code = 5'h1E;
  logic tx_serial = 1'b1;
  logic mac_send = 1'b0;
  logic [4:0] mac_code = 5'h15;
  logic txen, txer, rxer, crs, irq, rx_line_corrected;
  logic [3:0] txd, rxd;
  logic [15:0] reg_rdata;
  logic [4:0] scrambler_code;
  logic delimiter_insert_en, oob_signal_en, ext_fifo_en;
  logic far_end_fault_signal_en, baseline_wander_en, symbol_align_en;
  logic mlt3_en, scrambler_en, carrier_integrity_monitor_en;
  logic line_transmit_output_o, line_transmit_output_oe;
  logic [15:0] pats [4] = '{16'hFFFF, 16'h0000, 16'h5A5A, 16'hA5A5};
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  pacc_top dut (
    .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .rx_line, .repeater_strap, .cim_mode_select, .ten_base_mode,
    .rx_frame_active, .eof_error_event, .manchester_error_event,
    .rx_nibble, .rx_nibble_err, .rx_code_aligned, .rx_code_unaligned,
    .rx_valid_frame, .txen, .txer, .txd, .enc_code, .tx_serial, .rxd,
    .rxer, .crs, .rx_line_corrected, .scrambler_code, .delimiter_insert_en,
    .oob_signal_en, .ext_fifo_en, .far_end_fault_signal_en,
    .baseline_wander_en, .symbol_align_en, .mlt3_en, .scrambler_en,
    .carrier_integrity_monitor_en, .line_transmit_output_o,
    .line_transmit_output_oe
  );
  pacc_mac_model mac (.clock, .send(mac_send), .code(mac_code),
    .txen, .txer, .txd);

  // ----------
  // clock, timeout and tasks
  // ----------
  always #12.5 clock = ~clock;
  // cut a hang short
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp,
    input string what);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, what);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle
  task automatic do_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : do_reset
  task automatic pulse_events;
    @(posedge clock);
    eof_error_event <= 1'b1;
    manchester_error_event <= 1'b1;
    @(posedge clock);
    eof_error_event <= 1'b0;
    manchester_error_event <= 1'b0;
  endtask : pulse_events
  task automatic frame_end(input logic line);
    @(posedge clock);
    rx_line <= line;
    rx_frame_active <= 1'b1;
    repeat (8) @(posedge clock);
    rx_frame_active <= 1'b0;
    settle();
  endtask : frame_end

  // ----------
  // main sequence
  // ----------
  initial
  begin
    do_reset();
    rd(OFS_FAST_CONTROL, 16'h0000, "strap high");
    cim_mode_select <= 1'b1;
    do_reset();
    rd(OFS_FAST_CONTROL, CT_RESET, "strap select");
    repeater_strap <= 1'b0;
    cim_mode_select <= 1'b0;
    do_reset();
    rd(OFS_FAST_CONTROL, CT_RESET, "strap low");
    // every control bit set and cleared, steering checked
    foreach (pats[i])
    begin
      wr(OFS_FAST_CONTROL, pats[i]);
      rd(OFS_FAST_CONTROL, pats[i] & CT_WRITE_MASK, "control");
      check({5'h00, oob_signal_en, ext_fifo_en, far_end_fault_signal_en,
        baseline_wander_en, symbol_align_en, mlt3_en, scrambler_en,
        carrier_integrity_monitor_en, line_transmit_output_oe,
        line_transmit_output_o, delimiter_insert_en},
        {5'h00, pats[i][CT_OOB_EN], pats[i][CT_EXT_FIFO_EN],
        pats[i][CT_FEF_EN], !pats[i][CT_BLW_DIS], !pats[i][CT_BYP_ALIGN],
        !pats[i][CT_BYP_MLT3], !pats[i][CT_BYP_SCRAM],
        !pats[i][CT_CIM_DIS], !pats[i][CT_TX_DIS], !pats[i][CT_TX_DIS],
        !pats[i][CT_BYP_4B5B]}, "steering");
    end
    // coded traffic with the 4B5B stage bypassed, then with it back in use
    wr(OFS_FAST_CONTROL, 16'h0400);
    mac_send <= 1'b1;
    rx_valid_frame <= 1'b1;
    settle();
    check(16'(scrambler_code), 16'h0015, "tx code");
    check(16'({rxer, rxd}), 16'h000B, "rx aligned");
    check(16'(crs), 16'h0001, "carrier");
    @(posedge clock);
    mac_send <= 1'b0;
    settle();
    check(16'(scrambler_code), 16'h0000, "tx idle");
    wr(OFS_FAST_CONTROL, 16'h0480);
    settle();
    check(16'({rxer, rxd}), 16'h0014, "rx unaligned");
    wr(OFS_FAST_CONTROL, 16'h0000);
    rx_valid_frame <= 1'b0;
    settle();
    check(16'({rxer, rxd}), 16'h0016, "rx decoded");
    check(16'(scrambler_code), 16'h001E, "tx encoded");
    check(16'(crs), 16'h0000, "carrier off");
    // sticky errors, interrupt raise, mask and clear
    wr(OFS_IRQ_ENABLE, 16'h0006);
    pulse_events();
    rd(OFS_TEN_BASE_STATUS, 16'h0000, "events outside 10BASE-T");
    ten_base_mode <= 1'b1;
    pulse_events();
    rd(OFS_TEN_BASE_STATUS, 16'h0600, "error flags");
    check(16'(irq), 16'h0001, "irq raised");
    rd(OFS_IRQ_STATUS, 16'h0006, "irq status");
    rd(OFS_TEN_BASE_STATUS, 16'h0000, "flags cleared on read");
    wr(OFS_IRQ_ENABLE, 16'h0000);
    settle();
    check(16'(irq), 16'h0000, "irq masked");
    wr(OFS_IRQ_ENABLE, 16'h0006);
    wr(OFS_IRQ_CLEAR, 16'h0006);
    settle();
    check(16'(irq), 16'h0000, "irq cleared");
    rd(OFS_IRQ_STATUS, 16'h0000, "irq status cleared");
    // receive pair polarity found at frame end
    frame_end(1'b0);
    check(16'(rx_line_corrected), 16'h0001, "line corrected");
    rd(OFS_TEN_BASE_STATUS, 16'h0100, "polarity inverted");
    rd(OFS_IRQ_STATUS, 16'h0001, "polarity event");
    frame_end(1'b1);
    rd(OFS_TEN_BASE_STATUS, 16'h0000, "polarity correct");
    check(16'(rx_line_corrected), 16'h0001, "line straight");
    // unmapped and read-only places
    wr(OFS_TEN_BASE_STATUS, 16'hFFFF);
    rd(OFS_TEN_BASE_STATUS, 16'h0000, "status read only");
    rd(4'hF, 16'h0000, "unmapped");
    wrap_up();
  end
endmodule : tb_pacc_top
